//--- logic/init_cfg.svh
// constants for the serial controller initialisation sequencer
// Function
// - program modes, then enables, then interrupts
// - reset controller first by reset command write
// - at least 6 peripheral clocks between accesses
// - at least 11 peripheral clocks after reset
// - receiver and transmitter off during mode phase
// - baud generator, receiver, transmitter enabled in order
// - optional transmit crc reset then dma enable
// - reset external status command written twice
// - enable rx, tx, status interrupts keeping dma
// - master interrupt enable is the final write
// - shadow every write, rewrite kept bits unchanged
// - x16, two stop, no parity, 8-bit async
// - time constant 06h low, 00h high
// - clock pin source, generator off, loopback, then enables
`ifndef INIT_CFG_SVH
`define INIT_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// timing
`define CLK_NS          20
`define PCLK_NS         250
`define CYCLE_REC_PCLK  6
`define RESET_REC_PCLK  11
`define STROBE_NS       250
`define GAP_CYC         ((`CYCLE_REC_PCLK * `PCLK_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_GAP_CYC     ((`RESET_REC_PCLK * `PCLK_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC      ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W           8

////////////////////////////////////////////////////////////////////////////////
// device register numbers and command fields
`define REG_CMD         4'h0
`define REG_MASTER_IRQ  4'h9
`define PTR_HIGH_CMD    3'b001
`define PTR_LOW_CMD     3'b000
`define RST_BITS_HI     7
`define RST_BITS_LO     6

////////////////////////////////////////////////////////////////////////////////
// table groups and length
`define GRP_BASE        2'h0
`define GRP_CRC_DMA     2'h1
`define GRP_IRQ         2'h2
`define TBL_LEN         5'h14
`define IDX_W           5

// entry = {group, register, value, keep mask}
`define E_RESET    {2'h0, 4'h9, 8'hc0, 8'h00}
`define E_MODE4    {2'h0, 4'h4, 8'h4c, 8'h00}
`define E_RXCTL    {2'h0, 4'h3, 8'hc0, 8'h00}
`define E_TXCTL    {2'h0, 4'h5, 8'h60, 8'h00}
`define E_MIRQ0    {2'h0, 4'h9, 8'h00, 8'h00}
`define E_MISC10   {2'h0, 4'ha, 8'h00, 8'h00}
`define E_CLKSRC   {2'h0, 4'hb, 8'h56, 8'h00}
`define E_TCLOW    {2'h0, 4'hc, 8'h06, 8'h00}
`define E_TCHIGH   {2'h0, 4'hd, 8'h00, 8'h00}
`define E_MISC14   {2'h0, 4'he, 8'h10, 8'h00}
`define E_BRG_EN   {2'h0, 4'he, 8'h01, 8'h1e}
`define E_RX_EN    {2'h0, 4'h3, 8'h01, 8'hfe}
`define E_TX_EN    {2'h0, 4'h5, 8'h08, 8'hf7}
`define E_CRC_RST  {2'h1, 4'h0, 8'h80, 8'h00}
`define E_DMA_EN   {2'h1, 4'h1, 8'h80, 8'h64}
`define E_EXT_IE   {2'h2, 4'hf, 8'h08, 8'h00}
`define E_EXT_RST  {2'h2, 4'h0, 8'h10, 8'h00}
`define E_IRQ_SRC  {2'h2, 4'h1, 8'h12, 8'he4}
`define E_MIE      {2'h2, 4'h9, 8'h08, 8'h17}

////////////////////////////////////////////////////////////////////////////////
// software port map
`define SW_CTRL     8'h00
`define SW_STATUS   8'h04
`define SW_RAW      8'h08
`define SW_SHD_HI   2'h1
`define CTRL_START  0
`define CTRL_CRC    1
`define CTRL_IRQ    2
`define CTRL_CHAN   3

`endif

//--- logic/init_pkg.sv
// types shared by the initialisation sequencer
`include "init_cfg.svh"
package init_pkg;

  // one table step
  typedef struct packed {
    logic [1:0] grp;      // optional group
    logic [3:0] reg_num;  // device register number
    logic [7:0] val;      // bits to write
    logic [7:0] keep;     // bits taken from the shadow
  } init_entry_s;

  // software port request
  typedef struct packed {
    logic [7:0]  addr;   // byte address
    logic [31:0] wdata;  // write data
    logic        wr;     // write strobe
    logic        rd;     // read strobe
  } sw_req_s;

  // device control pins, all active low except selects
  typedef struct packed {
    logic ce_n;   // chip enable
    logic rd_n;   // read strobe
    logic wr_n;   // write strobe
    logic a_b;    // channel select, 1 = channel a
    logic d_c;    // 1 = data port, 0 = control port
  } dev_ctl_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_FETCH   = 3'b001,
    ST_EVAL    = 3'b011,
    ST_PTR_ACT = 3'b010,
    ST_PTR_GAP = 3'b110,
    ST_DAT_ACT = 3'b111,
    ST_DAT_GAP = 3'b101
  } seq_state_e;

endpackage

//--- logic/init_table_rom.sv
// initialisation table with registered read data
`include "init_cfg.svh"
module init_table_rom
  import init_pkg::*;
(
  input  wire logic              clk_sys,  // system clock
  input  wire logic              reset,    // async reset, active high
  input  wire logic [`IDX_W-1:0] addr,     // step index
  output init_entry_s            rdata     // entry, one cycle later
);

  init_entry_s rom_d;  // combinational lookup

  // mode phase, then enables, then optional crc/dma and interrupt steps
  always_comb begin
    case (addr)
      5'h00:   rom_d = `E_RESET;
      5'h01:   rom_d = `E_MODE4;
      5'h02:   rom_d = `E_RXCTL;
      5'h03:   rom_d = `E_TXCTL;
      5'h04:   rom_d = `E_MIRQ0;
      5'h05:   rom_d = `E_MISC10;
      5'h06:   rom_d = `E_CLKSRC;
      5'h07:   rom_d = `E_TCLOW;
      5'h08:   rom_d = `E_TCHIGH;
      5'h09:   rom_d = `E_MISC14;
      5'h0a:   rom_d = `E_BRG_EN;
      5'h0b:   rom_d = `E_RX_EN;
      5'h0c:   rom_d = `E_TX_EN;
      5'h0d:   rom_d = `E_CRC_RST;
      5'h0e:   rom_d = `E_DMA_EN;
      5'h0f:   rom_d = `E_EXT_IE;
      5'h10:   rom_d = `E_EXT_RST;
      5'h11:   rom_d = `E_EXT_RST;
      5'h12:   rom_d = `E_IRQ_SRC;
      5'h13:   rom_d = `E_MIE;
      default: rom_d = '0;
    endcase
  end

  // registered read port
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else begin
      rdata <= rom_d;
    end
  end

endmodule

//--- logic/serial_ctrl_init_sequence.sv
// host sequencer that initialises the serial controller over its bus pins
`include "init_cfg.svh"
module serial_ctrl_init_sequence
  import init_pkg::*;
(
  input  wire logic        clk_sys,      // system clock, 50 mhz
  input  wire logic        reset,        // async reset, active high
  input  wire sw_req_s     sw_req,       // software port request
  output logic [31:0]      sw_rdata,     // read data, cycle after read strobe
  output dev_ctl_s         dev_ctl,      // device control pins
  output logic [7:0]       dev_data_o,   // device data bus, driven value
  output logic             dev_data_oe   // high while driving the data bus
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  seq_state_e            state_q, state_d;   // sequencer state
  logic [`CNT_W-1:0]     cnt_q, cnt_d;       // strobe / recovery counter
  logic [`IDX_W-1:0]     idx_q, idx_d;       // table step
  init_entry_s           cur_q, cur_d;       // entry being written
  logic                  seq_q, seq_d;       // running the table, not a raw write
  logic                  done_q, done_d;     // table finished
  logic                  rst_hit_q, rst_hit_d; // last data write was a reset
  logic [3:1]            ctrl_q;             // crc enable, irq enable, channel
  logic [7:0]            shadow_q [16];      // last value written per register
  init_entry_s           rom_q;              // registered table output
  dev_ctl_s              ctl_d;              // next pin values
  logic [7:0]            data_d;             // next data bus value
  logic                  oe_d;               // next data enable
  logic [31:0]           rdata_d;            // next read data

  ////////////////////////////////////////////////////////////////////////////////
  // table

  init_table_rom u_rom (
    .clk_sys (clk_sys),
    .reset   (reset),
    .addr    (idx_q),
    .rdata   (rom_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  wire       wr_ctrl   = sw_req.wr && (sw_req.addr == `SW_CTRL);    // control write
  wire       wr_raw    = sw_req.wr && (sw_req.addr == `SW_RAW);     // single raw write
  wire       idle      = (state_q == ST_IDLE);                      // ready for orders
  wire       start     = wr_ctrl && sw_req.wdata[`CTRL_START] && idle;
  wire       raw_go    = wr_raw && idle && !start;                  // ignored while busy
  wire       at_end    = (idx_q == `TBL_LEN);                       // table exhausted
  wire       grp_ok    = (rom_q.grp == `GRP_BASE) ||
                         ((rom_q.grp == `GRP_CRC_DMA) && ctrl_q[`CTRL_CRC]) ||
                         ((rom_q.grp == `GRP_IRQ) && ctrl_q[`CTRL_IRQ]);
  // taken from the sources, not from cur_d, so no loop closes through the next-state logic
  wire       raw_ptr   = (sw_req.wdata[11:8] != `REG_CMD);          // reg 0 needs no pointer
  wire       rom_ptr   = (rom_q.reg_num != `REG_CMD);               // reg 0 needs no pointer
  // kept bits come from the shadow so mode bits survive the enable writes
  wire [7:0] merged    = (shadow_q[cur_q.reg_num] & cur_q.keep) |
                         (cur_q.val & ~cur_q.keep);
  wire [7:0] ptr_byte  = {2'b00, (cur_q.reg_num[3] ? `PTR_HIGH_CMD : `PTR_LOW_CMD),
                          cur_q.reg_num[2:0]};
  wire       is_reset  = (cur_q.reg_num == `REG_MASTER_IRQ) &&
                         (merged[`RST_BITS_HI:`RST_BITS_LO] != 2'b00);
  wire       cnt_last  = (cnt_q == `CNT_W'(1));                     // phase ends this cycle
  wire       strobe_up = (cnt_q == `CNT_W'(`STROBE_CYC));           // address setup cycle
  wire [`CNT_W-1:0] gap_ptr = `CNT_W'(`GAP_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer next state

  // walks the table in order; only whole groups are skipped, never reordered
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    idx_d     = idx_q;
    cur_d     = cur_q;
    seq_d     = seq_q;
    done_d    = done_q;
    rst_hit_d = rst_hit_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          // table starts with the reset command, then modes
          idx_d   = '0;
          seq_d   = 1'b1;
          done_d  = 1'b0;
          state_d = ST_FETCH;
        end else if (raw_go) begin
          // raw write: whole byte written, shadow follows it
          cur_d   = '{grp: `GRP_BASE, reg_num: sw_req.wdata[11:8],
                      val: sw_req.wdata[7:0], keep: 8'h00};
          seq_d   = 1'b0;
          cnt_d   = `CNT_W'(`STROBE_CYC);
          state_d = raw_ptr ? ST_PTR_ACT : ST_DAT_ACT;
        end
      end
      ST_FETCH: begin
        // rom output valid after this edge
        state_d = ST_EVAL;
      end
      ST_EVAL: begin
        if (at_end) begin
          done_d  = 1'b1;
          seq_d   = 1'b0;
          state_d = ST_IDLE;
        end else if (grp_ok) begin
          cur_d   = rom_q;
          cnt_d   = `CNT_W'(`STROBE_CYC);
          state_d = rom_ptr ? ST_PTR_ACT : ST_DAT_ACT;
        end else begin
          // optional step not wanted
          idx_d   = idx_q + `IDX_W'(1);
          state_d = ST_FETCH;
        end
      end
      ST_PTR_ACT: begin
        if (cnt_last) begin
          cnt_d   = gap_ptr;
          state_d = ST_PTR_GAP;
        end else begin
          cnt_d   = cnt_q - `CNT_W'(1);
        end
      end
      ST_PTR_GAP: begin
        if (cnt_last) begin
          cnt_d   = `CNT_W'(`STROBE_CYC);
          state_d = ST_DAT_ACT;
        end else begin
          cnt_d   = cnt_q - `CNT_W'(1);
        end
      end
      ST_DAT_ACT: begin
        if (cnt_last) begin
          rst_hit_d = is_reset;
          cnt_d     = is_reset ? `CNT_W'(`RST_GAP_CYC) : `CNT_W'(`GAP_CYC);
          state_d   = ST_DAT_GAP;
        end else begin
          cnt_d     = cnt_q - `CNT_W'(1);
        end
      end
      ST_DAT_GAP: begin
        // next step only after the full recovery gap
        if (cnt_last) begin
          cnt_d   = '0;
          if (seq_q) begin
            idx_d   = idx_q + `IDX_W'(1);
            state_d = ST_FETCH;
          end else begin
            state_d = ST_IDLE;
          end
        end else begin
          cnt_d   = cnt_q - `CNT_W'(1);
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin values, from the next state so the pins come out of flip-flops

  // the write strobe falls one cycle after data and select settle
  always_comb begin
    ctl_d      = '{ce_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                   a_b: ctrl_q[`CTRL_CHAN], d_c: 1'b0};
    data_d     = dev_data_o;
    oe_d       = 1'b0;
    case (state_d)
      ST_PTR_ACT: begin
        ctl_d.ce_n = 1'b0;
        ctl_d.wr_n = (cnt_d == `CNT_W'(`STROBE_CYC));
        data_d     = {2'b00, (cur_d.reg_num[3] ? `PTR_HIGH_CMD : `PTR_LOW_CMD),
                      cur_d.reg_num[2:0]};
        oe_d       = 1'b1;
      end
      ST_DAT_ACT: begin
        ctl_d.ce_n = 1'b0;
        ctl_d.wr_n = (cnt_d == `CNT_W'(`STROBE_CYC));
        data_d     = (shadow_q[cur_d.reg_num] & cur_d.keep) |
                     (cur_d.val & ~cur_d.keep);
        oe_d       = 1'b1;
      end
      default: begin
        data_d     = dev_data_o;                                    // hold last value
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer registers; leaving reset runs the long recovery gap, since the
  // device shares this reset and must not be touched until it has settled

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q   <= ST_DAT_GAP;
      cnt_q     <= `CNT_W'(`RST_GAP_CYC);
      idx_q     <= '0;
      cur_q     <= '0;
      seq_q     <= 1'b0;
      done_q    <= 1'b0;
      rst_hit_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      idx_q     <= idx_d;
      cur_q     <= cur_d;
      seq_q     <= seq_d;
      done_q    <= done_d;
      rst_hit_q <= rst_hit_d;
    end
  end

  // device pins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dev_ctl     <= '{ce_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a_b: 1'b0, d_c: 1'b0};
      dev_data_o  <= 8'h00;
      dev_data_oe <= 1'b0;
    end else begin
      dev_ctl     <= ctl_d;
      dev_data_o  <= data_d;
      dev_data_oe <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shadow of every byte written

  // updated at the end of the data strobe; the byte is stable the whole access
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        shadow_q[i] <= 8'h00;
      end
    end else if ((state_q == ST_DAT_ACT) && cnt_last) begin
      shadow_q[cur_q.reg_num] <= merged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers

  // options are frozen while a sequence runs so groups stay consistent
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q <= 3'h0;
    end else if (wr_ctrl && idle) begin
      ctrl_q <= sw_req.wdata[3:1];
    end
  end

  // read mux: control, status, register and pointer byte of the last write, shadow bytes
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sw_req.addr == `SW_CTRL) begin
      rdata_d = {28'h0000000, ctrl_q, 1'b0};
    end else if (sw_req.addr == `SW_STATUS) begin
      rdata_d = {16'h0000, 3'h0, idx_q, 5'h00, rst_hit_q, done_q, !idle};
    end else if (sw_req.addr == `SW_RAW) begin
      rdata_d = {20'h00000, cur_q.reg_num, ptr_byte};
    end else if (sw_req.addr[7:6] == `SW_SHD_HI) begin
      rdata_d = {24'h000000, shadow_q[sw_req.addr[5:2]]};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sw_rdata <= 32'h0000_0000;
    end else if (sw_req.rd) begin
      sw_rdata <= rdata_d;
    end else begin
      sw_rdata <= 32'h0000_0000;
    end
  end

endmodule

//--- tb/init_seq_sva.sv
// checker for the sequencer's device pins and software read port
`include "init_cfg.svh"
module init_seq_checker
  import init_pkg::*;
(
  input wire logic        clk_sys,     // system clock
  input wire logic        reset,       // async reset, active high
  input wire sw_req_s     sw_req,      // software request
  input wire logic [31:0] sw_rdata,    // software read data
  input wire dev_ctl_s    dev_ctl,     // device control pins
  input wire logic [7:0]  dev_data_o,  // device data value
  input wire logic        dev_data_oe  // device data enable
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP     = `GAP_CYC;      // ordinary recovery in clocks
  localparam int RST_GAP = `RST_GAP_CYC;  // recovery after a reset command
  logic [7:0] hi_cnt_q;  // clocks with chip enable high
  logic [7:0] last_d_q;  // byte of the latest access
  logic [7:0] prev_d_q;  // byte of the access before it
  logic       ce_q;      // chip enable one clock ago
  wire        ce_fall = ce_q & ~dev_ctl.ce_n;  // an access begins
  // a pointer to register 9 followed by either reset bit means a reset command
  wire        rst_cmd = (prev_d_q == 8'h09) && (last_d_q[7:6] != 2'b00);
  wire  [7:0] need    = rst_cmd ? 8'(RST_GAP) : 8'(GAP);

  ////////////////////////////////////////////////////////////////////////////////
  // idle stretch and last two bytes; the counter saturates so long idles never wrap
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hi_cnt_q <= 8'h00;
      last_d_q <= 8'hc0;  // reset reads as a reset command, so the first access
      prev_d_q <= 8'h09;  // must also wait the long recovery
      ce_q     <= 1'b1;
    end else begin
      ce_q     <= dev_ctl.ce_n;
      hi_cnt_q <= !dev_ctl.ce_n ? 8'h00 : (&hi_cnt_q) ? hi_cnt_q : hi_cnt_q + 8'h01;
      if (!dev_ctl.ce_n) last_d_q <= dev_data_o;
      if (ce_fall) prev_d_q <= last_d_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // twelve clocks of write strobe
  sequence strobe_s;
    !dev_ctl.wr_n [*8] ##1 !dev_ctl.wr_n [*4];
  endsequence
  // setup clock, strobe, then release of chip enable and write strobe
  sequence access_s;
    dev_ctl.wr_n ##1 strobe_s ##1 (dev_ctl.ce_n && dev_ctl.wr_n);
  endsequence
  rd_idle_a: assert property (dev_ctl.rd_n) else $error("device read strobe asserted");
  ctrl_port_a: assert property (!dev_ctl.d_c) else $error("data port selected");
  oe_match_a: assert property (dev_data_oe == !dev_ctl.ce_n) else $error("bus enable out of step");
  wr_in_ce_a: assert property (!dev_ctl.wr_n |-> !dev_ctl.ce_n) else $error("write strobe outside access");
  bus_stable_a: assert property (!dev_ctl.ce_n && !$past(dev_ctl.ce_n) |-> $stable(dev_data_o) && $stable(dev_ctl.a_b))
    else $error("bus changed inside access");
  access_shape_a: assert property ($fell(dev_ctl.ce_n) |-> access_s) else $error("bad access shape");
  gap_min_a: assert property (ce_fall |-> hi_cnt_q >= need) else $error("recovery gap too short");
  rdata_idle_a: assert property (!sw_req.rd |=> sw_rdata == 32'h0) else $error("read data outside slot");
endmodule

//--- tb/serial_dev_model.sv
// behavioural model of the serial controller as seen through its write port
module serial_dev_model
  import init_pkg::*;
(
  input wire logic       clk_sys,  // system clock
  input wire logic       reset,    // hardware reset
  input wire dev_ctl_s   dev_ctl,  // control pins from the host
  input wire logic [7:0] dev_bus   // level on the data bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  regs [2][16];  // write registers, index 1 = channel a
  logic [12:0] log_q [$];     // {channel, register, value} per completed write
  logic [3:0]  ptr_q;         // pending register pointer, 0 when none
  logic [7:0]  lat_q;         // byte latched while the strobe is low
  logic        ab_q;          // channel of the latched byte
  logic        wr_q;          // write strobe one clock ago

  // a reset command turns the channel off: receiver, transmitter, modem bits, interrupts
  task automatic chan_reset(input logic [1:0] bits);
    for (int c = 0; c < 2; c++) begin
      if (bits[1 - c] && c == 1 || bits[1] && c == 1 || bits[0] && c == 0) begin
        regs[c][3][0] = 1'b0;
        regs[c][5][3] = 1'b0;
        regs[c][5][7] = 1'b0;
        regs[c][5][1] = 1'b0;
        regs[c][1]    = 8'h00;
      end
    end
  endtask

  // a byte to the control port is a pointer, a register value or a command
  task automatic commit();
    logic [3:0] p;
    p = {lat_q[5:3] == 3'b001, lat_q[2:0]};
    if (ptr_q != 4'h0) begin
      regs[ab_q][ptr_q] = lat_q;
      log_q.push_back({ab_q, ptr_q, lat_q});
      if (ptr_q == 4'h9) chan_reset(lat_q[7:6]);
      ptr_q = 4'h0;
    end else if (p != 4'h0) begin
      ptr_q = p;
    end else begin
      regs[ab_q][0] = lat_q;
      log_q.push_back({ab_q, 4'h0, lat_q});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // the byte is taken at the rising edge of the write strobe
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ptr_q = 4'h0;
      wr_q = 1'b1;
      foreach (regs[c, r]) regs[c][r] = 8'h00;
    end else begin
      if (!dev_ctl.ce_n && !dev_ctl.wr_n) begin
        lat_q = dev_bus;
        ab_q = dev_ctl.a_b;
      end
      if (!wr_q && dev_ctl.wr_n) commit();
      wr_q = dev_ctl.wr_n;
    end
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the initialisation sequencer
`include "init_cfg.svh"
module testbench;
  import init_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys;      // 50 mhz clock
  logic        reset;        // async reset
  sw_req_s     sw_req;       // software request
  logic [31:0] sw_rdata;     // software read data
  dev_ctl_s    dev_ctl;      // device pins
  logic [7:0]  dev_data_o;   // bus value
  logic        dev_data_oe;  // bus enable
  // a released bus drifts away from its last value
  wire  [7:0]  dev_bus = dev_data_oe ? dev_data_o : ~dev_data_o;
  int          failures;     // mismatches
  int          check_count;  // comparisons
  int          cycles;       // clocks since start
  logic [31:0] rv;           // last read value
  // expected {register, value} of the full table
  logic [11:0] exp_tbl [20] = '{12'h9c0, 12'h44c, 12'h3c0, 12'h560, 12'h900, 12'ha00, 12'hb56, 12'hc06,
    12'hd00, 12'he10, 12'he11, 12'h3c1, 12'h568, 12'h080, 12'h180, 12'hf08, 12'h010, 12'h010, 12'h192, 12'h908};

  serial_ctrl_init_sequence DUT (.clk_sys(clk_sys), .reset(reset), .sw_req(sw_req), .sw_rdata(sw_rdata),
    .dev_ctl(dev_ctl), .dev_data_o(dev_data_o), .dev_data_oe(dev_data_oe));
  serial_dev_model partner (.clk_sys(clk_sys), .reset(reset), .dev_ctl(dev_ctl), .dev_bus(dev_bus));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      $display("ERROR %0t run timed out", $time);
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // access tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    sw_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    sw_req.wr <= 1'b0;
  endtask
  // read data stands only in the clock after the strobe
  task automatic sw_read(input logic [7:0] a);
    @(posedge clk_sys);
    sw_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    sw_req.rd <= 1'b0;
    #1 rv = sw_rdata;
  endtask
  // poll busy with a bound so a stuck sequencer cannot hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      sw_read(`SW_STATUS);
      n++;
    end while (rv[0] !== 1'b0 && n < 5000);
    if (n == 5000) begin
      failures++;
      $display("ERROR %0t sequencer stayed busy", $time);
    end
  endtask
  task automatic wait_log(input int cnt);
    for (int i = 0; i < 3000 && partner.log_q.size() < cnt; i++) @(posedge clk_sys);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sw_req = '0;
    reset = 1'b1;
    failures = 0;
    check_count = 0;
    cycles = 0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    sw_read(`SW_STATUS);
    check(rv, 32'h1, "busy in reset recovery");
    wait_idle();
    sw_read(`SW_STATUS);
    check(rv, 32'h0, "status after reset");
    sw_read(8'h30);
    check(rv, 32'h0, "unmapped read");
    // full table on channel a, optional groups included
    sw_write(`SW_CTRL, 32'hf);
    sw_read(`SW_STATUS);
    check(32'(rv[0]), 32'h1, "busy after start");
    sw_write(`SW_CTRL, 32'h1);
    wait_idle();
    sw_read(`SW_STATUS);
    check(rv, 32'h1402, "done after table");
    sw_read(`SW_CTRL);
    check(rv, 32'he, "control kept while busy");
    check(32'(partner.log_q.size()), 32'h14, "full table length");
    for (int i = 0; i < 20; i++) check(32'(partner.log_q[i]), 32'({1'b1, exp_tbl[i]}), "table write");
    sw_read(8'h44);
    check(rv, 32'h92, "dma kept in irq enable");
    sw_read(8'h64);
    check(rv, 32'h08, "master enable last");
    sw_read(8'h78);
    check(rv, 32'h11, "generator enable byte");
    // bare table on channel b, optional groups skipped
    partner.log_q.delete();
    sw_write(`SW_CTRL, 32'h1);
    wait_idle();
    check(32'(partner.log_q.size()), 32'hd, "bare table length");
    for (int i = 0; i < 13; i++) check(32'(partner.log_q[i]), 32'({1'b0, exp_tbl[i]}), "bare write");
    // raw channel reset then an ordinary write; the checker watches the longer gap
    partner.log_q.delete();
    sw_write(`SW_RAW, 32'h980);
    wait_log(1);
    wait_idle();
    sw_read(`SW_STATUS);
    check(32'(rv[2]), 32'h1, "reset command flagged");
    sw_write(`SW_RAW, 32'hc0e);
    wait_log(2);
    wait_idle();
    check(32'(partner.log_q[0]), 32'h0980, "raw reset write");
    check(32'(partner.log_q[1]), 32'h0c0e, "raw value write");
    sw_read(`SW_STATUS);
    check(32'(rv[2]), 32'h0, "reset flag cleared");
    sw_read(`SW_RAW);
    check(rv, 32'hc0c, "raw pointer byte");
    results();
  end
endmodule

bind serial_ctrl_init_sequence init_seq_checker chk (.clk_sys(clk_sys), .reset(reset), .sw_req(sw_req),
  .sw_rdata(sw_rdata), .dev_ctl(dev_ctl), .dev_data_o(dev_data_o), .dev_data_oe(dev_data_oe));
